// ===== logic/ddr_link_device.sv
/*
  Command, clock and strobe logic of an 8-bank x8 DDR3L-style memory,
  with a small flop store and an APB slave for latency configuration.
  Assumes every memory pin is asynchronous to pclk and far slower than
  it; ck and dqs are oversampled, so link edges must be >= 3 pclk apart.
*/
// Chosen here: the register offsets and register access over APB.
// Operation
// - Commands sampled at ck rising crossing
// - Write data captured on both strobe edges
// - Read strobe edge aligned, write strobe centred
// - Eight independent banks, 64M bytes each; the flop store keeps only 16 bytes of each
// - Burst of eight or chopped four
// - Sequential and interleaved burst ordering
// - Read latency 5 to 11 and 13
// - Write latency 5 to 9
// - Additive latency posts column commands early
// - Auto and self refresh, interval watched
// - Optional auto precharge after each burst
// - Clock enable gates inputs and drivers
// - Clock enable low picks power-down or self-refresh
// - Self-refresh exit needs no clock edge
// - Power-down listens only to ck and cke
// - Self-refresh listens only to cke
// - Chip select high masks the command
// - Masked write beats are discarded
`timescale 1ns/1ps
module ddr_link_device (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic ck, // Link clock, true
  input wire logic ck_n, // Link clock, complement
  input wire ddr_link_pkg::cmd_pins_t cmd, // Command and address pins
  input wire ddr_link_pkg::data_in_t din, // Data, strobe, mask in
  output ddr_link_pkg::data_out_t dout // Data and strobe drive
);
  import ddr_link_pkg::*;

  function automatic logic [2:0] burst_col(input logic [2:0] start,
                                           input logic [2:0] beat,
                                           input logic ilv);
    logic [1:0] low;
    low = start[1:0] + beat[1:0];
    if (ilv) begin
      burst_col = start ^ beat;
    end else begin
      burst_col = {start[2] ^ beat[2], low};
    end
  endfunction

  function automatic logic [6:0] mem_idx(input logic [2:0] ba,
                                         input logic [3:0] col);
    mem_idx = {ba, col};
  endfunction

  function automatic logic cl_ok(input logic [3:0] v);
    cl_ok = (v >= 4'h5 && v <= 4'hb) || v == 4'hd;
  endfunction

  // Synchronisers, two flops on every pin
  cmd_pins_t cmd_s1, cmd_s2;
  data_in_t din_s1, din_s2;
  logic ck_s1, ck_s2, ck_q, ckn_s1, ckn_s2, dqs_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_s1 <= '0;
      cmd_s2 <= '0;
      din_s1 <= '0;
      din_s2 <= '0;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_q <= 1'b0;
      ckn_s1 <= 1'b0;
      ckn_s2 <= 1'b0;
      dqs_q <= 1'b0;
    end else begin
      cmd_s1 <= cmd;
      cmd_s2 <= cmd_s1;
      din_s1 <= din;
      din_s2 <= din_s1;
      ck_s1 <= ck;
      ck_s2 <= ck_s1;
      ck_q <= ck_s2;
      ckn_s1 <= ck_n;
      ckn_s2 <= ckn_s1;
      dqs_q <= din_s2.dqs;
    end
  end

  logic ck_rise, ck_fall, dqs_edge;
  assign ck_rise = ck_s2 & ~ck_q & ~ckn_s2;
  assign ck_fall = ~ck_s2 & ck_q;
  assign dqs_edge = din_s2.dqs ^ dqs_q;

  // Configuration and APB slave
  logic [3:0] cl, cwl, al;
  logic ilv, hot;
  logic [1:0] blm;
  logic [3:0] next_cl, next_cwl, next_al;
  logic next_ilv, next_hot;
  logic [1:0] next_blm;
  logic [31:0] next_prdata, rd_val;
  logic next_pready, next_pslverr, apb_wr, clr_late, mapped;
  pwr_t pwr;
  logic [BANKS-1:0] open;
  logic late;
  logic [15:0] ref_cnt;

  always_comb begin
    next_cl = cl;
    next_cwl = cwl;
    next_al = al;
    next_ilv = ilv;
    next_hot = hot;
    next_blm = blm;
    mapped = paddr == CTRL_OFS || paddr == STATUS_OFS ||
             paddr == REFCNT_OFS;
    rd_val = '0;
    case (paddr)
      CTRL_OFS: begin
        rd_val[CL_LSB +: 4] = cl;
        rd_val[CWL_LSB +: 4] = cwl;
        rd_val[AL_LSB +: 4] = al;
        rd_val[ILV_BIT] = ilv;
        rd_val[BLM_LSB +: 2] = blm;
        rd_val[HOT_BIT] = hot;
      end
      STATUS_OFS: begin
        rd_val[PWR_LSB +: 2] = pwr;
        rd_val[OPEN_LSB +: BANKS] = open;
        rd_val[LATE_BIT] = late;
        rd_val[SREF_BIT] = pwr == PWR_SREF;
      end
      REFCNT_OFS: rd_val[15:0] = ref_cnt;
      default: rd_val = '0;
    endcase
    next_pready = psel & penable & ~pready;
    next_pslverr = next_pready & ~mapped;
    next_prdata = (next_pready & ~pwrite) ? rd_val : '0;
    apb_wr = psel & penable & pready & pwrite;
    clr_late = apb_wr && paddr == STATUS_OFS && pwdata[LATE_BIT];
    if (apb_wr && paddr == CTRL_OFS) begin
      // Unsupported latencies are dropped, old value kept
      if (cl_ok(pwdata[CL_LSB +: 4])) begin
        next_cl = pwdata[CL_LSB +: 4];
      end
      if (pwdata[CWL_LSB +: 4] >= 4'h5 && pwdata[CWL_LSB +: 4] <= 4'h9) begin
        next_cwl = pwdata[CWL_LSB +: 4];
      end
      next_al = pwdata[AL_LSB +: 4];
      next_ilv = pwdata[ILV_BIT];
      next_blm = pwdata[BLM_LSB +: 2];
      next_hot = pwdata[HOT_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl <= CL_RST;
      cwl <= CWL_RST;
      al <= AL_RST;
      ilv <= 1'b0;
      hot <= 1'b0;
      blm <= BL_FIXED8;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cl <= next_cl;
      cwl <= next_cwl;
      al <= next_al;
      ilv <= next_ilv;
      hot <= next_hot;
      blm <= next_blm;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Command decode, banks, power and refresh
  cmd_t op;
  pwr_t next_pwr;
  logic [BANKS-1:0] next_open;
  logic cke_q, next_cke_q, next_late, armed, next_armed;
  logic [15:0] next_ref_cnt;
  logic [10:0] refi_cnt, next_refi_cnt, refi_lim;
  logic cs_sel, cmd_valid, refresh_now, len4_cmd, rd_go, wr_go;
  logic rd_busy, wr_busy, rd_close, wr_close;
  logic [2:0] rd_bank, wr_bank;

  assign op = cmd_t'({cmd_s2.ras_n, cmd_s2.cas_n, cmd_s2.we_n});
  assign cs_sel = ck_rise & ~cmd_s2.cs_n;
  // Host must hold cke over the previous and current edge
  assign cmd_valid = cs_sel & pwr == PWR_ON & cke_q & cmd_s2.cke;
  assign refresh_now = cmd_valid && op == CMD_REF && open == '0;
  assign len4_cmd = blm == BL_FIXED4 ||
                    (blm == BL_OTF && !cmd_s2.addr[BC_BIT]);
  assign rd_go = cmd_valid && op == CMD_RD && open[cmd_s2.ba] && !rd_busy;
  assign wr_go = cmd_valid && op == CMD_WR && open[cmd_s2.ba] && !wr_busy;
  assign refi_lim = hot ? REFI_HOT_CYC : REFI_NORM_CYC;

  always_comb begin
    next_pwr = pwr;
    next_open = open;
    next_cke_q = cke_q;
    next_armed = armed;
    next_ref_cnt = ref_cnt;
    next_refi_cnt = refi_cnt;
    if (ck_rise) begin
      next_cke_q = cmd_s2.cke;
    end
    case (pwr)
      PWR_ON: begin
        if (ck_rise & cke_q & ~cmd_s2.cke) begin
          if (cs_sel && op == CMD_REF && open == '0) begin
            next_pwr = PWR_SREF;
          end else if (|open) begin
            next_pwr = PWR_APD;
          end else begin
            next_pwr = PWR_PPD;
          end
        end
      end
      // Only ck and cke are looked at here
      PWR_PPD, PWR_APD: begin
        if (ck_rise & cmd_s2.cke) begin
          next_pwr = PWR_ON;
        end
      end
      // Clock may stand still; cke alone wakes the device
      PWR_SREF: begin
        if (cmd_s2.cke) begin
          next_pwr = PWR_ON;
          next_cke_q = 1'b1;
        end
      end
      default: next_pwr = PWR_ON;
    endcase
    if (cmd_valid) begin
      case (op)
        CMD_ACT: next_open[cmd_s2.ba] = 1'b1;
        CMD_PRE: begin
          if (cmd_s2.addr[AP_BIT]) begin
            next_open = '0;
          end else begin
            next_open[cmd_s2.ba] = 1'b0;
          end
        end
        default: next_open = next_open;
      endcase
    end
    if (rd_close) begin
      next_open[rd_bank] = 1'b0;
    end
    if (wr_close) begin
      next_open[wr_bank] = 1'b0;
    end
    // Self-refresh refreshes internally, so the interval restarts
    if (refresh_now || pwr == PWR_SREF) begin
      next_refi_cnt = '0;
      if (refresh_now) begin
        next_armed = 1'b1;
        next_ref_cnt = ref_cnt + 16'h0001;
      end
    end else if (armed && refi_cnt < refi_lim) begin
      next_refi_cnt = refi_cnt + 11'h001;
    end
    // A new overdue event beats a clear in the same cycle
    // Compare is >= so a shorter hot interval cannot be stepped over
    next_late = (late & ~clr_late) | (armed && refi_cnt >= refi_lim);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr <= PWR_ON;
      open <= '0;
      cke_q <= 1'b0;
      late <= 1'b0;
      armed <= 1'b0;
      ref_cnt <= '0;
      refi_cnt <= '0;
    end else begin
      pwr <= next_pwr;
      open <= next_open;
      cke_q <= next_cke_q;
      late <= next_late;
      armed <= next_armed;
      ref_cnt <= next_ref_cnt;
      refi_cnt <= next_refi_cnt;
    end
  end

  // Write path and flop store
  logic [7:0] mem [STORE_WORDS];
  logic [7:0] next_mem [STORE_WORDS];
  logic wr_open, next_wr_open, next_wr_busy, wr_len4, next_wr_len4;
  logic wr_ap, next_wr_ap, wr_ilv, next_wr_ilv, wr_last;
  logic [4:0] wr_wait, next_wr_wait;
  logic [3:0] wr_beat, next_wr_beat;
  logic [2:0] next_wr_bank;
  logic [3:0] wr_col, next_wr_col;

  assign wr_last = wr_beat == (wr_len4 ? BEATS_BC4 : BEATS_BL8) - 4'h1;
  // Beats arrive on strobe edges only while input buffers are on
  assign wr_close = wr_open & dqs_edge & cmd_s2.cke & wr_last & wr_ap;

  always_comb begin
    next_mem = mem;
    next_wr_open = wr_open;
    next_wr_busy = wr_busy;
    next_wr_len4 = wr_len4;
    next_wr_ap = wr_ap;
    next_wr_ilv = wr_ilv;
    next_wr_wait = wr_wait;
    next_wr_beat = wr_beat;
    next_wr_bank = wr_bank;
    next_wr_col = wr_col;
    if (wr_go) begin
      next_wr_busy = 1'b1;
      next_wr_wait = {1'b0, al} + {1'b0, cwl};
      next_wr_len4 = len4_cmd;
      next_wr_ap = cmd_s2.addr[AP_BIT];
      next_wr_ilv = ilv;
      next_wr_bank = cmd_s2.ba;
      next_wr_col = cmd_s2.addr[STORE_COL_BITS-1:0];
    end else if (wr_busy && !wr_open && ck_rise) begin
      next_wr_wait = wr_wait - 5'h01;
      if (wr_wait == 5'h01) begin
        next_wr_open = 1'b1;
        next_wr_beat = '0;
      end
    end
    // Strobe is centred on data, so dq is settled at its edge
    if (wr_open && dqs_edge && cmd_s2.cke) begin
      if (!din_s2.dm) begin
        next_mem[mem_idx(wr_bank, {wr_col[3], burst_col(wr_col[2:0],
          wr_beat[2:0], wr_ilv)})] = din_s2.dq;
      end
      next_wr_beat = wr_beat + 4'h1;
      if (wr_last) begin
        next_wr_open = 1'b0;
        next_wr_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STORE_WORDS; i++) begin
        mem[i] <= '0;
      end
      wr_open <= 1'b0;
      wr_busy <= 1'b0;
      wr_len4 <= 1'b0;
      wr_ap <= 1'b0;
      wr_ilv <= 1'b0;
      wr_wait <= '0;
      wr_beat <= '0;
      wr_bank <= '0;
      wr_col <= '0;
    end else begin
      mem <= next_mem;
      wr_open <= next_wr_open;
      wr_busy <= next_wr_busy;
      wr_len4 <= next_wr_len4;
      wr_ap <= next_wr_ap;
      wr_ilv <= next_wr_ilv;
      wr_wait <= next_wr_wait;
      wr_beat <= next_wr_beat;
      wr_bank <= next_wr_bank;
      wr_col <= next_wr_col;
    end
  end

  // Read path, strobe follows ck so it is edge aligned with data
  data_out_t next_dout;
  logic rd_act, next_rd_act, next_rd_busy, rd_len4, next_rd_len4;
  logic rd_ap, next_rd_ap, rd_ilv, next_rd_ilv, rd_end;
  logic [4:0] rd_wait, next_rd_wait;
  logic [3:0] rd_beat, next_rd_beat, rd_col, next_rd_col;
  logic [2:0] next_rd_bank;

  assign rd_end = rd_beat == (rd_len4 ? BEATS_BC4 : BEATS_BL8);
  assign rd_close = rd_act & (ck_rise | ck_fall) & rd_end & rd_ap;

  always_comb begin
    next_dout = dout;
    next_rd_act = rd_act;
    next_rd_busy = rd_busy;
    next_rd_len4 = rd_len4;
    next_rd_ap = rd_ap;
    next_rd_ilv = rd_ilv;
    next_rd_wait = rd_wait;
    next_rd_beat = rd_beat;
    next_rd_bank = rd_bank;
    next_rd_col = rd_col;
    if (rd_go) begin
      next_rd_busy = 1'b1;
      next_rd_wait = {1'b0, al} + {1'b0, cl};
      next_rd_len4 = len4_cmd;
      next_rd_ap = cmd_s2.addr[AP_BIT];
      next_rd_ilv = ilv;
      next_rd_bank = cmd_s2.ba;
      next_rd_col = cmd_s2.addr[STORE_COL_BITS-1:0];
    end else if (rd_busy && !rd_act && ck_rise) begin
      next_rd_wait = rd_wait - 5'h01;
      if (rd_wait == 5'h01) begin
        next_rd_act = 1'b1;
        next_rd_beat = 4'h0;
      end
    end
    if ((rd_act || next_rd_act) && (ck_rise || ck_fall)) begin
      if (rd_act && rd_end) begin
        next_rd_act = 1'b0;
        next_rd_busy = 1'b0;
        next_dout = '0;
      end else begin
        next_dout.dq = mem[mem_idx(rd_bank, {rd_col[3], burst_col(
          rd_col[2:0], next_rd_beat[2:0], rd_ilv)})];
        next_dout.dqs = ck_rise;
        next_dout.dq_oe = 1'b1;
        next_dout.dqs_oe = 1'b1;
        next_rd_beat = next_rd_beat + 4'h1;
      end
    end
    // Drivers off whenever cke is low
    if (!cmd_s2.cke) begin
      next_dout.dq_oe = 1'b0;
      next_dout.dqs_oe = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= '0;
      rd_act <= 1'b0;
      rd_busy <= 1'b0;
      rd_len4 <= 1'b0;
      rd_ap <= 1'b0;
      rd_ilv <= 1'b0;
      rd_wait <= '0;
      rd_beat <= '0;
      rd_bank <= '0;
      rd_col <= '0;
    end else begin
      dout <= next_dout;
      rd_act <= next_rd_act;
      rd_busy <= next_rd_busy;
      rd_len4 <= next_rd_len4;
      rd_ap <= next_rd_ap;
      rd_ilv <= next_rd_ilv;
      rd_wait <= next_rd_wait;
      rd_beat <= next_rd_beat;
      rd_bank <= next_rd_bank;
      rd_col <= next_rd_col;
    end
  end
endmodule

// ===== logic/ddr_link_pkg.sv
/*
  Shared constants and types for the DDR3L-style memory device logic:
  pin groups, command codes, power states, register map and timing.
  Assumes a 100 MHz system clock and an APB master for configuration.
*/
package ddr_link_pkg;
  localparam int CLK_MHZ = 100;
  // Average refresh interval, normal and hot case temperature
  localparam int REFI_NORM_NS = 7800;
  localparam int REFI_HOT_NS = 3900;
  localparam logic [10:0] REFI_NORM_CYC = 11'(REFI_NORM_NS * CLK_MHZ / 1000);
  localparam logic [10:0] REFI_HOT_CYC = 11'(REFI_HOT_NS * CLK_MHZ / 1000);

  localparam int BANKS = 8;
  localparam int ROW_BITS = 16;
  localparam int COL_BITS = 10;
  // Flop storage keeps only the low column bits of each bank
  localparam int STORE_COL_BITS = 4;
  localparam int STORE_WORDS = BANKS << STORE_COL_BITS;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;

  // APB register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] REFCNT_OFS = 12'h008;
  // Control fields
  localparam int CL_LSB = 0;
  localparam int CWL_LSB = 4;
  localparam int AL_LSB = 8;
  localparam int ILV_BIT = 12;
  localparam int BLM_LSB = 13;
  localparam int HOT_BIT = 15;
  // Status fields
  localparam int PWR_LSB = 0;
  localparam int OPEN_LSB = 2;
  localparam int LATE_BIT = 10;
  localparam int SREF_BIT = 11;
  // Values after reset and burst length mode codes
  localparam logic [3:0] CL_RST = 4'hb;
  localparam logic [3:0] CWL_RST = 4'h8;
  localparam logic [3:0] AL_RST = 4'h0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // Command code {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
    CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_ZQ = 3'h6, CMD_NOP = 3'h7
  } cmd_t;

  typedef enum logic [1:0] {PWR_ON, PWR_PPD, PWR_APD, PWR_SREF} pwr_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [ROW_BITS-1:0] addr;
  } cmd_pins_t;

  typedef struct packed {
    logic [7:0] dq;
    logic dqs;
    logic dm;
  } data_in_t;

  typedef struct packed {
    logic [7:0] dq;
    logic dq_oe;
    logic dqs;
    logic dqs_oe;
  } data_out_t;
endpackage

// ===== testbench/ddr_link_checker.sv
/*
  Port checker for ddr_link_device: APB handshake and read-side drive.
  Assumes the bind below attaches it to every device instance.
*/
`timescale 1ns/1ps
module ddr_link_checker (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic ck, // Link clock
  input wire logic ck_n, // Link clock bar
  input wire ddr_link_pkg::cmd_pins_t cmd, // Command pins
  input wire ddr_link_pkg::data_in_t din, // Data in
  input wire ddr_link_pkg::data_out_t dout // Data out
);
  import ddr_link_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_wait;
    $rose(psel && penable) |-> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait) else $error("ready not one wait");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_unmapped;
    pready && paddr > 12'h008 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_err_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray error");
  property p_rd_zero;
    !(pready && !pwrite) |-> prdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("stray read data");
  property p_oe_pair;
    dout.dq_oe |-> dout.dqs_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("strobe not driven");
  property p_edge;
    dout.dq_oe && $past(dout.dq_oe) && $stable(dout.dqs) |-> $stable(dout.dq);
  endproperty
  a_edge: assert property (p_edge) else $error("data off strobe edge");
  property p_hold;
    dout.dq_oe && $changed(dout.dq) |=> $stable(dout.dq) [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("beat too short");
  property p_cke;
    !cmd.cke [*6] |-> !dout.dq_oe;
  endproperty
  a_cke: assert property (p_cke) else $error("drive with cke low");
endmodule

bind ddr_link_device ddr_link_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ck(ck), .ck_n(ck_n), .cmd(cmd), .din(din), .dout(dout));

// ===== testbench/ddr_host_model.sv
/*
  Behavioural memory controller on the link side of the device.
  Assumes a running pclk; ck moves only inside these tasks.
*/
`timescale 1ns/1ps
module ddr_host_model (
  input wire logic pclk, // System clock
  output logic ck, // Link clock
  output logic ck_n, // Link clock bar
  output ddr_link_pkg::cmd_pins_t cmd, // Command pins
  output ddr_link_pkg::data_in_t din, // Data, strobe, mask
  input wire ddr_link_pkg::data_out_t dout // Device drive
);
  import ddr_link_pkg::*;
  logic [7:0] rq_dq[$];
  logic rq_dqs[$];
  int rq_hp[$];
  int hp = 0;
  int hc = 0;
  bit pend = 1'b0;
  cmd_pins_t rel;
  assign ck_n = ~ck;
  initial begin
    ck = 1'b0;
    cmd = {5'h1f, 19'h0};
    din = 10'h0;
  end
  // Half ck period of 8 pclk; strobe mid-half centres write data
  task automatic half(input bit tog);
    repeat (4) @(posedge pclk);
    if (tog)
      din.dqs <= ~din.dqs;
    // Release lands mid-half, well clear of the sampling ck edge
    if (pend) begin
      cmd <= rel;
      pend = 1'b0;
    end
    repeat (3) @(posedge pclk);
    if (dout.dq_oe === 1'b1) begin
      rq_dq.push_back(dout.dq);
      rq_dqs.push_back(dout.dqs);
      rq_hp.push_back(hp);
    end
    @(posedge pclk);
    ck <= ~ck;
    hp++;
  endtask
  task automatic idle(input int n);
    repeat (n) half(1'b0);
  endtask
  // Command held across the rising edge; cke kept for the access
  task automatic go(input bit cke, input bit cs_n, input cmd_t c,
                    input logic [2:0] ba, input logic [15:0] a);
    cmd <= {cke, cs_n, c, ba, a};
    half(1'b0);
    hc = hp;
    rel = {cke, 1'b1, CMD_NOP, 3'h0, 16'h0};
    pend = 1'b1;
    half(1'b0);
  endtask
  task automatic wr(input int l, input logic [7:0] d[8],
                    input logic [7:0] m, input int n);
    repeat (2 * l - 1) half(1'b0);
    for (int i = 0; i < n; i++) begin
      din.dq <= d[i];
      din.dm <= m[i];
      half(1'b1);
    end
    din.dq <= ~din.dq; // Released: inverse of last byte
    din.dm <= 1'b0;
    half(1'b0);
  endtask
  task automatic cke_on();
    cmd.cke <= 1'b1;
  endtask
endmodule

// ===== testbench/ddr_link_device_test.sv
/*
  Self-checking bench for ddr_link_device: APB master here, link pins
  from ddr_host_model; the checker is bound in its own file.
*/
`timescale 1ns/1ps
module ddr_link_device_test;
  import ddr_link_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, n;
  logic [3:0] cur;
  logic ck, ck_n;
  cmd_pins_t cmd;
  data_in_t din;
  data_out_t dout;
  logic [7:0] mem[16];
  logic [7:0] d[8];
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  ddr_link_device dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ck(ck),
    .ck_n(ck_n), .cmd(cmd), .din(din), .dout(dout));
  ddr_host_model host_u (.pclk(pclk), .ck(ck), .ck_n(ck_n), .cmd(cmd),
    .din(din), .dout(dout));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                      input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  function automatic logic [3:0] bo(input logic [3:0] c, input int i,
                                    input bit il);
    logic [2:0] k;
    k = 3'(i);
    if (il)
      return {c[3], c[2:0] ^ k};
    return {c[3], c[2] ^ k[2], c[1:0] + k[1:0]};
  endfunction
  task automatic wburst(input logic [15:0] a, input logic [7:0] m,
                        input logic [7:0] base);
    for (int i = 0; i < 8; i++) begin
      d[i] = base + 8'(i);
      if (!m[i])
        mem[bo(a[3:0], i, 1'b0)] = d[i];
    end
    host_u.go(1'b1, 1'b0, CMD_WR, 3'h3, a);
    host_u.wr(5, d, m, 8);
  endtask
  task automatic flush();
    host_u.rq_dq.delete();
    host_u.rq_dqs.delete();
    host_u.rq_hp.delete();
  endtask
  task automatic rburst(input logic [15:0] a, input int rl, input int k,
                        input bit il);
    flush();
    host_u.go(1'b1, 1'b0, CMD_RD, 3'h3, a);
    host_u.idle(2 * rl + k + 2);
    chk(host_u.rq_dq.size(), k, "beat count");
    for (int i = 0; i < k && i < host_u.rq_dq.size(); i++) begin
      chk(host_u.rq_dq[i], mem[bo(a[3:0], i, il)], "byte");
      chk(host_u.rq_dqs[i], !i[0], "strobe");
      chk(host_u.rq_hp[i], host_u.hc + 2 * rl + i, "beat time");
    end
  endtask
  task automatic t_regs();
    rchk(CTRL_OFS, 32'h0000008b, "ctrl reset");
    rchk(STATUS_OFS, 32'h0, "status reset");
    rchk(REFCNT_OFS, 32'h0, "refcnt reset");
    apb(1'b0, 12'h00c, 32'h0);
    chk(err, 1'b1, "unmapped");
    cur = 4'hb;
    for (int v = 4; v < 15; v++) begin
      if ((v >= 5 && v <= 11) || v == 13)
        cur = 4'(v);
      apb(1'b1, CTRL_OFS, 32'h80 | 32'(v));
      rchk(CTRL_OFS, {24'h0, 4'h8, cur}, "cas latency");
    end
    cur = 4'h8;
    for (int v = 4; v < 11; v++) begin
      if (v >= 5 && v <= 9)
        cur = 4'(v);
      apb(1'b1, CTRL_OFS, 32'hd | (32'(v) << 4));
      rchk(CTRL_OFS, {24'h0, cur, 4'hd}, "write latency");
    end
    apb(1'b1, CTRL_OFS, 32'h2055);
    $display("registers done");
  endtask
  task automatic t_burst();
    host_u.idle(4);
    host_u.go(1'b1, 1'b0, CMD_ACT, 3'h3, 16'h8001);
    rchk(STATUS_OFS, 32'h20, "bank open");
    wburst(16'h1000, 8'h00, 8'ha0);
    wburst(16'h1000, 8'h08, 8'h50);
    rburst(16'h1002, 5, 8, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h3255);
    rburst(16'h0405, 7, 4, 1'b1);
    rchk(STATUS_OFS, 32'h0, "auto precharge");
    $display("bursts done");
  endtask
  task automatic t_pwr();
    host_u.go(1'b1, 1'b1, CMD_ACT, 3'h1, 16'h0);
    rchk(STATUS_OFS, 32'h0, "deselected");
    for (int b = 0; b < 8; b++)
      host_u.go(1'b1, 1'b0, CMD_ACT, 3'(b), 16'h0);
    rchk(STATUS_OFS, 32'h3fc, "all banks");
    host_u.go(1'b1, 1'b0, CMD_PRE, 3'h7, 16'h0);
    rchk(STATUS_OFS, 32'h1fc, "one bank closed");
    host_u.go(1'b0, 1'b1, CMD_NOP, 3'h0, 16'h0);
    rchk(STATUS_OFS, 32'h1fe, "active pd");
    flush();
    host_u.go(1'b0, 1'b0, CMD_RD, 3'h0, 16'h1000);
    host_u.idle(30);
    chk(host_u.rq_dq.size(), 0, "pd read");
    host_u.go(1'b1, 1'b1, CMD_NOP, 3'h0, 16'h0);
    host_u.idle(2);
    host_u.go(1'b1, 1'b0, CMD_PRE, 3'h0, 16'h0400);
    rchk(STATUS_OFS, 32'h0, "pd exit");
    host_u.go(1'b0, 1'b1, CMD_NOP, 3'h0, 16'h0);
    rchk(STATUS_OFS, 32'h1, "precharge pd");
    host_u.go(1'b1, 1'b1, CMD_NOP, 3'h0, 16'h0);
    host_u.idle(2);
    host_u.go(1'b0, 1'b0, CMD_REF, 3'h0, 16'h0);
    rchk(STATUS_OFS, 32'h803, "self refresh");
    host_u.cke_on();
    repeat (8) @(posedge pclk);
    rchk(STATUS_OFS, 32'h0, "exit without ck");
    $display("power done");
  endtask
  task automatic t_ref();
    host_u.idle(2);
    for (int h = 0; h < 2; h++) begin
      apb(1'b1, CTRL_OFS, h ? 32'hb255 : 32'h3255);
      apb(1'b0, REFCNT_OFS, 32'h0);
      n = rd;
      host_u.go(1'b1, 1'b0, CMD_REF, 3'h0, 16'h0);
      rchk(REFCNT_OFS, n + 32'h1, "refresh count");
      apb(1'b1, STATUS_OFS, 32'h400);
      repeat (int'(h ? REFI_HOT_CYC : REFI_NORM_CYC) - 60) @(posedge pclk);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[10], 1'b0, "early");
      repeat (60) @(posedge pclk);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[10], 1'b1, "late");
    end
    $display("refresh done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_burst();
    t_pwr();
    t_ref();
    close_out();
  end
endmodule
